// ===== core/imr_consts.vh
`ifndef IMR_CONSTS_VH
`define IMR_CONSTS_VH
// message address window and field positions
`define IMR_ADDR_HI_VAL    12'hFEE
`define IMR_DEST_HI        19
`define IMR_DEST_LO        4
`define IMR_DID_HI         19
`define IMR_DID_LO         12
`define IMR_BUSID_HI       12
`define IMR_BUSID_LO       11
`define IMR_HINT_BIT       3
`define IMR_DM_BIT         2
`define IMR_PB_DM_BIT      5
// processor bus request encodings for an interrupt transaction
`define IMR_REQ_FIRST_INT  5'h09
`define IMR_REQ_SECOND_INT 5'h1C
// data word fields
`define IMR_TRIG_BIT       15
`define IMR_DSTAT_BIT      14
`define IMR_DMODE_HI       10
`define IMR_DMODE_LO       8
`define IMR_VEC_HI         7
`define IMR_VEC_LO         0
// avalon register offsets (byte addresses)
`define IMR_REG_CTRL       4'h0
`define IMR_REG_ENABLE     4'h4
`define IMR_REG_STATUS     4'h8
`define IMR_REG_LASTDATA   4'hC
`define IMR_CTRL_RST       32'h0000_0000
`define IMR_ENABLE_RST     32'h0000_00FF
// transaction kinds on the processor bus output
`define IMR_KIND_INT       2'h0
`define IMR_KIND_INTA      2'h1
`define IMR_KIND_EOI       2'h2
`define IMR_KIND_LEGACY    2'h3
`endif

// ===== core/imr_router.v
// Behaviour
// - processor interrupt is request codes 01001/11100
// - destination from address middle, control low nibble
// - address bit 3 is redirect hint
// - mode bit A2 on link, Ab5 on bus
// - one data transfer per message
// - link-bound interrupts issued as plain writes
// - data: trigger, status, delivery mode, vector
// - upper destination byte is identifier; rest unused
// - directed interrupts seen on every bus
// - routing ignores cluster and identifier fields
// - bus ids 0..3 after reset, overridable
// - physical all-ones destination is broadcast
// - redirectable converted to directed before delivery
// - redirection in flat and cluster logical modes, any source
// - cluster: upper nibble cluster, lower agents
// - cluster lower nibble all ones is broadcast
// - cluster redirection stays inside cluster
// - accept legacy, acknowledge and end-of-interrupt
// - no sideband interrupt wires, bus transactions only
// - global flat/cluster bit resets to flat
`timescale 1ns/10ps
`default_nettype none
`include "imr_consts.vh"
module imr_router #(
  parameter NUM_BUS = 4
) (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // serial link inbound message (one write = one message)
  input  wire        link_valid_i,
  input  wire [31:0] link_addr_i,
  input  wire [31:0] link_data_i,
  input  wire        link_legacy_i,
  // processor bus inbound request
  input  wire        pbus_valid_i,
  input  wire [1:0]  pbus_src_i,
  input  wire [4:0]  request_code_first_i,
  input  wire [4:0]  request_code_second_i,
  input  wire [31:0] pbus_addr_i,
  input  wire [31:0] pbus_data_i,
  input  wire        pbus_inta_i,
  input  wire        pbus_eoi_i,
  // power-on bus id override
  input  wire        power_on_bus_id_override_i,
  input  wire [7:0]  power_on_bus_ids_i,
  // delivery to processor buses
  output reg  [3:0]  pbus_out_valid_o,
  output reg  [1:0]  pbus_out_kind_o,
  output reg  [31:0] pbus_out_addr_o,
  output reg  [31:0] pbus_out_data_o,
  output reg  [7:0]  pbus_bus_ids_o,
  // delivery to the link as a plain memory write
  output reg         link_wr_o,
  output reg  [31:0] link_wr_addr_o,
  output reg  [31:0] link_wr_data_o,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest
);

  reg        cluster_mode;
  reg [7:0]  agent_enable;
  reg [7:0]  lru_ptr;
  reg [15:0] msg_count;
  reg [31:0] last_data;
  reg        bad_req;
  reg        bus_ack;

  // lowest-priority pick: first enabled candidate at or after rotating pointer
  function [7:0] pick;
    input [7:0] cand;
    input [2:0] start;
    input [2:0] width;
    integer k;
    reg [2:0] idx;
    reg       found;
    begin
      pick  = 8'h00;
      found = 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        idx = start + k[2:0];
        if (!found && idx <= width && cand[idx]) begin
          pick      = 8'h01 << idx;
          found     = 1'b1;
        end
      end
    end
  endfunction

  // detect message sources
  // acknowledge and end-of-interrupt requests are never taken as messages
  wire pb_is_int = pbus_valid_i && !pbus_inta_i && !pbus_eoi_i &&
                   request_code_first_i == `IMR_REQ_FIRST_INT &&
                   request_code_second_i == `IMR_REQ_SECOND_INT;
  wire link_is_int = link_valid_i && !link_legacy_i &&
                     link_addr_i[31:20] == `IMR_ADDR_HI_VAL;
  wire use_pb = pb_is_int;
  wire [31:0] m_addr = use_pb ? pbus_addr_i : link_addr_i;
  wire [31:0] m_data = use_pb ? pbus_data_i : link_data_i;
  wire m_valid = pb_is_int | link_is_int;

  // field decode
  wire [15:0] dest_field = m_addr[`IMR_DEST_HI:`IMR_DEST_LO];
  wire [7:0]  dest_id    = m_addr[`IMR_DID_HI:`IMR_DID_LO];
  wire        hint       = m_addr[`IMR_HINT_BIT];
  wire        dmode      = use_pb ? m_addr[`IMR_PB_DM_BIT] : m_addr[`IMR_DM_BIT];
  wire [2:0]  del_mode   = m_data[`IMR_DMODE_HI:`IMR_DMODE_LO];
  wire        broadcast_phys = !dmode && dest_id == 8'hFF;
  wire        cl_bcast   = dmode && cluster_mode && dest_id[3:0] == 4'hF;

  // redirection: rewrite destination identifier and clear hint bit 3
  reg [7:0]  next_dest;
  reg        next_redir;
  reg [7:0]  win;
  always @* begin
    next_dest  = dest_id;
    next_redir = 1'b0;
    win        = 8'h00;
    if (hint) begin
      next_redir = 1'b1;
      if (dmode && !cluster_mode) begin
        win = pick(dest_id & agent_enable, lru_ptr[2:0], 3'h7);
        if (win != 8'h00)
          next_dest = win;
      end else if (dmode) begin
        win = pick({4'h0, dest_id[3:0] & agent_enable[3:0]}, {1'b0, lru_ptr[1:0]},
                   3'h3);
        if (win != 8'h00)
          next_dest = {dest_id[7:4], win[3:0]};
      end
    end
  end

  wire [31:0] out_addr = {m_addr[31:20], next_dest, m_addr[11:4],
                          1'b0, m_addr[2:0]};

  // routing and delivery; every bus sees each message taken, a processor interrupt wins over a same-cycle link message
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pbus_out_valid_o <= 4'h0;
      pbus_out_kind_o  <= `IMR_KIND_INT;
      pbus_out_addr_o  <= 32'h0000_0000;
      pbus_out_data_o  <= 32'h0000_0000;
      link_wr_o        <= 1'b0;
      link_wr_addr_o   <= 32'h0000_0000;
      link_wr_data_o   <= 32'h0000_0000;
      lru_ptr          <= 8'h00;
      msg_count        <= 16'h0000;
      last_data        <= 32'h0000_0000;
      bad_req          <= 1'b0;
    end else begin
      pbus_out_valid_o <= 4'h0;
      link_wr_o        <= 1'b0;
      if (m_valid) begin
        // broadcast to all buses regardless of identifier bits
        pbus_out_valid_o <= 4'hF;
        pbus_out_kind_o  <= `IMR_KIND_INT;
        pbus_out_addr_o  <= hint ? out_addr : m_addr;
        pbus_out_data_o  <= m_data;
        last_data        <= {9'h000, broadcast_phys, cl_bcast, del_mode,
                             m_data[`IMR_TRIG_BIT], m_data[`IMR_DSTAT_BIT],
                             m_data[`IMR_VEC_HI:`IMR_VEC_LO], dest_field[7:0]};
        msg_count        <= msg_count + 16'h0001;
        if (next_redir)
          lru_ptr <= lru_ptr + 8'h01;
      end else if (link_valid_i && link_legacy_i) begin
        pbus_out_valid_o <= 4'hF;
        pbus_out_kind_o  <= `IMR_KIND_LEGACY;
        pbus_out_addr_o  <= link_addr_i;
        pbus_out_data_o  <= link_data_i;
      end else if (pbus_valid_i && pbus_inta_i) begin
        // acknowledge goes out to the link as a plain write
        link_wr_o      <= 1'b1;
        link_wr_addr_o <= pbus_addr_i;
        link_wr_data_o <= pbus_data_i;
      end else if (pbus_valid_i && pbus_eoi_i) begin
        link_wr_o      <= 1'b1;
        link_wr_addr_o <= pbus_addr_i;
        link_wr_data_o <= pbus_data_i;
      end else if (pbus_valid_i) begin
        bad_req <= 1'b1;
      end
      if (avs_write && !avs_waitrequest && avs_address == `IMR_REG_STATUS &&
          avs_writedata[0] && !(pbus_valid_i && !m_valid && !pbus_inta_i &&
          !pbus_eoi_i))
        bad_req <= 1'b0;
    end
  end

  // bus id straps: loaded on every clock while the override is high
  always @(posedge sys_clk_i) begin
    if (sys_rst_i)
      pbus_bus_ids_o <= 8'hE4;
    else if (power_on_bus_id_override_i)
      pbus_bus_ids_o <= power_on_bus_ids_i;
  end

  // avalon slave: one wait cycle, then answer
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      bus_ack         <= 1'b0;
      cluster_mode    <= 1'b0;
      agent_enable    <= 8'hFF;
    end else begin
      bus_ack         <= (avs_read | avs_write) & !bus_ack;
      avs_waitrequest <= !((avs_read | avs_write) & !bus_ack);
      if ((avs_read | avs_write) & !bus_ack) begin
        case (avs_address)
          `IMR_REG_CTRL:     avs_readdata <= {31'h0, cluster_mode};
          `IMR_REG_ENABLE:   avs_readdata <= {24'h0, agent_enable};
          `IMR_REG_STATUS:   avs_readdata <= {15'h0, msg_count, bad_req};
          `IMR_REG_LASTDATA: avs_readdata <= last_data;
          default:           avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (avs_write && !avs_waitrequest) begin
        case (avs_address)
          `IMR_REG_CTRL:   cluster_mode <= avs_writedata[0];
          `IMR_REG_ENABLE: agent_enable <= avs_writedata[7:0];
          default:         ;
        endcase
      end
    end
  end

endmodule // imr_router
`default_nettype wire

// ===== tb/imr_router_chk.sv
`timescale 1ns/10ps
`default_nettype none
module imr_router_chk (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        link_valid_i,
  input wire logic [31:0] link_addr_i,
  input wire logic [31:0] link_data_i,
  input wire logic        pbus_valid_i,
  input wire logic [4:0]  request_code_first_i,
  input wire logic [4:0]  request_code_second_i,
  input wire logic        pbus_eoi_i,
  input wire logic [31:0] pbus_addr_i,
  input wire logic [3:0]  pbus_out_valid_o,
  input wire logic [31:0] pbus_out_addr_o,
  input wire logic [31:0] pbus_out_data_o,
  input wire logic        link_wr_o,
  input wire logic [31:0] link_wr_addr_o
);
  wire logic lm;
  // a link write in the message window with no bus request beside it
  assign lm = link_valid_i && link_addr_i[31:20] == 12'hFEE && !pbus_valid_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_link_fanout: assert property (lm |=> pbus_out_valid_o == 4'hF)
    else $error("link message missed a bus");
  a_data_kept: assert property (lm |=> pbus_out_data_o == $past(link_data_i))
    else $error("message data altered");
  a_direct_addr: assert property (lm && !link_addr_i[3] |=> pbus_out_addr_o == $past(link_addr_i))
    else $error("directed address altered");
  a_hint_clear: assert property (lm && link_addr_i[3] |=> !pbus_out_addr_o[3])
    else $error("hint left set");
  a_proc_int: assert property (pbus_valid_i && request_code_first_i == 5'h09 &&
    request_code_second_i == 5'h1C && !pbus_eoi_i |=> pbus_out_valid_o == 4'hF)
    else $error("processor interrupt not delivered");
  a_bad_code: assert property (pbus_valid_i && request_code_first_i != 5'h09 && !link_valid_i
    |=> pbus_out_valid_o == 4'h0)
    else $error("unknown request delivered");
  a_no_stray: assert property (pbus_out_valid_o != 4'h0 |-> $past(link_valid_i || pbus_valid_i))
    else $error("delivery without a message");
  a_eoi_fwd: assert property (pbus_valid_i && pbus_eoi_i |=>
    link_wr_o && link_wr_addr_o == $past(pbus_addr_i))
    else $error("end of interrupt not forwarded");
endmodule // imr_router_chk
bind imr_router imr_router_chk u_imr_router_chk (.*);
`default_nettype wire

// ===== tb/imr_proc_model.sv
`timescale 1ns/10ps
`default_nettype none
module imr_proc_model (
  input  wire logic        valid_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  id_i,
  input  wire logic        cluster_i,
  output logic             claim_o
);
  logic [7:0] d;
  // processor claim decision by destination mode
  always_comb begin
    d = addr_i[19:12];
    if (!addr_i[2])
      claim_o = valid_i && (d == id_i || d == 8'hFF);
    else if (!cluster_i)
      claim_o = valid_i && (d & id_i) != 8'h00;
    else
      claim_o = valid_i && d[7:4] == id_i[7:4] && (d[3:0] & id_i[3:0]) != 4'h0;
  end
endmodule // imr_proc_model
`default_nettype wire

// ===== tb/imr_router_bench.sv
`timescale 1ns/10ps
`default_nettype none
module imr_router_bench;
  logic        sys_clk_i = 1'b0, sys_rst_i = 1'b1, link_valid_i = 1'b0, link_legacy_i = 1'b0;
  logic        pbus_valid_i = 1'b0, pbus_inta_i = 1'b0, pbus_eoi_i = 1'b0, cl = 1'b0;
  logic        power_on_bus_id_override_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [1:0]  pbus_src_i = 2'h0;
  logic [4:0]  request_code_first_i = 5'h00, request_code_second_i = 5'h00;
  logic [3:0]  avs_address = 4'h0, pbus_out_valid_o;
  logic [7:0]  power_on_bus_ids_i = 8'h00, pid = 8'h00, pbus_bus_ids_o;
  logic [31:0] link_addr_i = 32'h0, link_data_i = 32'h0, pbus_addr_i = 32'h0;
  logic [31:0] pbus_data_i = 32'h0, avs_writedata = 32'h0;
  logic [31:0] pbus_out_addr_o, pbus_out_data_o, link_wr_addr_o, link_wr_data_o, avs_readdata;
  logic [1:0]  pbus_out_kind_o;
  logic        link_wr_o, avs_waitrequest, claim;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  imr_router u_imr_router (.*);
  imr_proc_model u_imr_proc_model (.valid_i(pbus_out_valid_o[0]), .addr_i(pbus_out_addr_o),
    .id_i(pid), .cluster_i(cl), .claim_o(claim));
  always #50 sys_clk_i = ~sys_clk_i;
  task automatic conclude;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded run length
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  // one link write, outputs sampled in the answer cycle
  task automatic lmsg(input logic [31:0] a, input logic g);
    @(posedge sys_clk_i);
    link_addr_i <= a;
    link_data_i <= 32'h0000_C123;
    link_legacy_i <= g;
    link_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    link_valid_i <= 1'b0;
    #1;
  endtask
  task automatic pmsg(input logic [4:0] f, input logic [4:0] s, input logic e);
    @(posedge sys_clk_i);
    request_code_first_i <= f;
    request_code_second_i <= s;
    pbus_addr_i <= 32'hFEE0_5000;
    pbus_eoi_i <= e;
    pbus_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    pbus_valid_i <= 1'b0;
    #1;
  endtask
  // avalon access held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  initial begin
    logic [31:0] q;
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("bus ids", 32'hE4, {24'h0, pbus_bus_ids_o});
    av(1'b0, 4'h0, 32'h0, q);
    chk("mode", 32'h0, q);
    av(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 32'h0, q);
    pid = 8'h05;
    lmsg(32'hFEE0_5000, 1'b0);
    chk("fanout", 32'hF, {28'h0, pbus_out_valid_o});
    chk("data", 32'hC123, pbus_out_data_o);
    chk("claim", 32'h1, {31'h0, claim});
    lmsg(32'hFEE0_6000, 1'b0);
    chk("no claim", 32'h0, {31'h0, claim});
    lmsg(32'hFEEF_F000, 1'b0);
    chk("broadcast", 32'h1, {31'h0, claim});
    lmsg(32'hFEE0_C00C, 1'b0);
    chk("hint", 32'h0, {31'h0, pbus_out_addr_o[3]});
    chk("agents", 32'h1, $countones(pbus_out_addr_o[19:12]));
    chk("in set", 32'h0, {24'h0, pbus_out_addr_o[19:12] & 8'hF3});
    av(1'b1, 4'h0, 32'h1, q);
    cl = 1'b1;
    pid = 8'h32;
    lmsg(32'hFEE3_F004, 1'b0);
    chk("cluster bc", 32'h1, {31'h0, claim});
    lmsg(32'hFEE3_F00C, 1'b0);
    chk("cluster", 32'h3, {28'h0, pbus_out_addr_o[19:16]});
    chk("agent", 32'h1, $countones(pbus_out_addr_o[15:12]));
    pmsg(5'h09, 5'h1C, 1'b0);
    chk("proc int", 32'hF, {28'h0, pbus_out_valid_o});
    pmsg(5'h09, 5'h00, 1'b0);
    chk("bad code", 32'h0, {28'h0, pbus_out_valid_o});
    av(1'b0, 4'h8, 32'h0, q);
    chk("bad flag", 32'h1, {31'h0, q[0]});
    pmsg(5'h09, 5'h1C, 1'b1);
    chk("eoi write", 32'h1, {31'h0, link_wr_o});
    chk("eoi addr", 32'hFEE0_5000, link_wr_addr_o);
    chk("eoi data", 32'h0, link_wr_data_o);
    lmsg(32'hFEE0_5000, 1'b1);
    chk("legacy", 32'h3, {30'h0, pbus_out_kind_o});
    @(posedge sys_clk_i);
    power_on_bus_ids_i <= 8'h1B;
    power_on_bus_id_override_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("override", 32'h1B, {24'h0, pbus_bus_ids_o});
    conclude();
  end
endmodule // imr_router_bench
`default_nettype wire
